// >>> core/ebi_pkg.sv
// Constants shared by the external memory bus interface.
// Assumes a single core clock domain; no software registers.
package ebi_pkg;
  // ----------------------------------------------------------------
  // Widths and routing
  // ----------------------------------------------------------------
  localparam int          EBI_AW         = 16;
  localparam logic [15:0] ROM_LO         = 16'h2000;
  localparam logic [15:0] ROM_HI         = 16'h2FFF;
  localparam logic        PROG_ENTRY_LVL = 1'b1;
  localparam logic [3:0]  PMODE_RESET    = 4'h0;
  localparam logic [15:0] DATA_RESET     = 16'h0000;
  // ----------------------------------------------------------------
  // Bus cycle phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBI_IDLE = 2'b00,
    EBI_ADDR = 2'b01,
    EBI_DATA = 2'b10,
    EBI_DONE = 2'b11
  } ebi_state_t;
endpackage : ebi_pkg

// >>> core/ebi_route.sv
// Routing decision for one access: on-chip ROM window or external bus.
// Assumes the external-access level has already been latched at reset release.
`timescale 1ns/10ps
module ebi_route (
  input  wire logic [ebi_pkg::EBI_AW-1:0] addr,
  input  wire logic                       ext_access_latched_n,
  output logic                            go_external
);
  import ebi_pkg::*;
  always_comb begin
    if (!ext_access_latched_n) begin
      go_external = 1'b1;
    end else begin
      go_external = !((addr >= ROM_LO) && (addr <= ROM_HI));
    end
  end
endmodule : ebi_route

// >>> core/ebi_core.sv
// External memory bus interface: multiplexed address/data master.
// Assumes a core request port (one access at a time) and synchronous pins.
// What this block does
// - Address phase then 8/16-bit data phase
// - Address-valid strobe only for external accesses
// - Address-valid low through cycle, high after
// - Latch strobe marks start of external cycle
// - Latch strobe held for the address phase only
// - Upper byte enable on word/high accesses of 16-bit cycles
// - Upper enable with byte bit selects bytes
// - Width pin sizes cycle when enabled
// - Width pin honoured during config fetch
// - External-access low sends all accesses off-chip
// - External-access high: ROM window served on-chip
// - External-access sampled only at reset release
// - Programming level with nonzero mode pins at release enters programming mode
// - Fetch indicator high only for external instruction fetch
`timescale 1ns/10ps
module ebi_core (
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  // Core request side
  input  wire logic                       req_valid,
  input  wire logic [ebi_pkg::EBI_AW-1:0] req_addr,
  input  wire logic                       req_write,
  input  wire logic                       req_word,
  input  wire logic                       req_fetch,
  input  wire logic                       req_cfg_fetch,
  input  wire logic [15:0]                req_wdata,
  input  wire logic                       dyn_width_enable,
  input  wire logic                       strobe_is_latch,
  output logic                            req_done,
  output logic                            req_internal,
  output logic [15:0]                     rd_data,
  output logic                            program_mode,
  output logic [3:0]                      program_mode_latched,
  // Pins
  input  wire logic [7:0]                 addr_data_upper_in,
  input  wire logic [7:0]                 addr_data_lower_in,
  output logic [7:0]                      addr_data_upper_out,
  output logic [7:0]                      addr_data_lower_out,
  output logic                            addr_data_oe_n,
  output logic                            addr_strobe,
  output logic                            upper_byte_enable_n,
  output logic                            fetch_indicator,
  input  wire logic                       dynamic_width_select,
  input  wire logic                       external_access_n,
  input  wire logic [3:0]                 program_mode_select
);
  import ebi_pkg::*;

  ebi_state_t state;
  logic       reset_seen;
  logic       ext_latched_n;
  logic       go_external;
  logic       wide;
  logic       next_wide;
  logic       cur_write;
  logic       cur_word;
  logic       cur_fetch;
  logic [15:0] cur_addr;
  logic [15:0] cur_wdata;

  // --------------------------------------------------------------
  // Reset-release capture
  // --------------------------------------------------------------
  // Straps are caught on the first clock after release, never by reset itself.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reset_seen           <= 1'b0;
      ext_latched_n        <= 1'b0;
      program_mode         <= 1'b0;
      program_mode_latched <= PMODE_RESET;
    end else if (!reset_seen) begin
      reset_seen           <= 1'b1;
      ext_latched_n        <= external_access_n;
      program_mode         <= 1'b0;
      program_mode_latched <= program_mode_select;
      if (external_access_n == PROG_ENTRY_LVL && program_mode_select != PMODE_RESET) begin
        program_mode <= 1'b1;
      end
    end
  end

  ebi_route u_route (
    .addr                 (req_addr),
    .ext_access_latched_n (ext_latched_n),
    .go_external          (go_external)
  );

  // Width of the cycle about to start; the config fetch always obeys the width pin
  assign next_wide = (dyn_width_enable || req_cfg_fetch) ? dynamic_width_select : 1'b1;

  // --------------------------------------------------------------
  // Bus cycle sequencer
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state     <= EBI_IDLE;
      cur_addr  <= DATA_RESET;
      cur_wdata <= DATA_RESET;
      cur_write <= 1'b0;
      cur_word  <= 1'b0;
      cur_fetch <= 1'b0;
      wide      <= 1'b1;
    end else begin
      unique case (state)
        EBI_IDLE: begin
          if (req_valid && reset_seen && !program_mode && go_external) begin
            state     <= EBI_ADDR;
            cur_addr  <= req_addr;
            cur_wdata <= req_wdata;
            cur_write <= req_write;
            cur_word  <= req_word;
            cur_fetch <= req_fetch && !req_cfg_fetch;
            // Width pin counts even for the config fetch itself
            wide <= next_wide;
          end
        end
        EBI_ADDR: state <= EBI_DATA;
        EBI_DATA: state <= EBI_DONE;
        EBI_DONE: state <= EBI_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      addr_data_upper_out <= 8'h00;
      addr_data_lower_out <= 8'h00;
      addr_data_oe_n      <= 1'b1;
    end else if (state == EBI_IDLE && req_valid && reset_seen && !program_mode && go_external) begin
      addr_data_upper_out <= req_addr[15:8];
      addr_data_lower_out <= req_addr[7:0];
      addr_data_oe_n      <= 1'b0;
    end else if (state == EBI_ADDR) begin
      // High byte of a narrow bus rides on the low lanes
      addr_data_upper_out <= cur_wdata[15:8];
      addr_data_lower_out <= (!wide && cur_addr[0]) ? cur_wdata[15:8] : cur_wdata[7:0];
      addr_data_oe_n      <= !cur_write;
    end else if (state == EBI_DATA) begin
      addr_data_oe_n      <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      // Idle level of the selected behaviour, so valid style never reads as asserted
      addr_strobe <= !strobe_is_latch;
    end else if (strobe_is_latch) begin
      // Latch style: rise at cycle start, fall at the end of the address phase
      if (state == EBI_IDLE && req_valid && reset_seen && !program_mode && go_external) begin
        addr_strobe <= 1'b1;
      end else if (state == EBI_ADDR) begin
        addr_strobe <= 1'b0;
      end
    end else begin
      // Address-valid style, active low, asserted for the whole external cycle
      // Rises on the edge that ends the data phase, together with the done pulse
      addr_strobe <= !((state == EBI_IDLE && req_valid && reset_seen && !program_mode && go_external)
                       || state == EBI_ADDR);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      upper_byte_enable_n <= 1'b1;
      fetch_indicator     <= 1'b0;
    end else if (state == EBI_IDLE && req_valid && reset_seen && !program_mode && go_external) begin
      // Upper lanes carry nothing in an 8-bit cycle, so the enable stays off there
      upper_byte_enable_n <= !(next_wide && (req_word || req_addr[0]));
      fetch_indicator     <= req_fetch && !req_cfg_fetch;
    end else if (state == EBI_DONE || state == EBI_IDLE) begin
      upper_byte_enable_n <= 1'b1;
      fetch_indicator     <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Completion and read data
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      req_done     <= 1'b0;
      req_internal <= 1'b0;
      rd_data      <= DATA_RESET;
    end else begin
      req_internal <= state == EBI_IDLE && req_valid && reset_seen && !program_mode && !go_external;
      req_done     <= (state == EBI_DATA)
                      || (state == EBI_IDLE && req_valid && reset_seen && !program_mode && !go_external);
      if (state == EBI_DATA && !cur_write) begin
        rd_data <= (wide || cur_word) ? {addr_data_upper_in, addr_data_lower_in}
                                      : {8'h00, addr_data_lower_in};
      end
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_valid_held: assert property (@(posedge core_clk) disable iff (!nrst)
    (!strobe_is_latch && state == EBI_ADDR) |-> !addr_strobe ##1 !addr_strobe ##1 addr_strobe)
    else $error("address valid not held over cycle");
  a_valid_ext_only: assert property (@(posedge core_clk) disable iff (!nrst)
    (!strobe_is_latch && state == EBI_IDLE && $past(state) == EBI_IDLE) |-> addr_strobe)
    else $error("address valid without external cycle");
  a_latch_start: assert property (@(posedge core_clk) disable iff (!nrst)
    (strobe_is_latch && state == EBI_ADDR) |-> addr_strobe)
    else $error("latch strobe missing at cycle start");
  a_addr_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == EBI_ADDR) |-> ({addr_data_upper_out, addr_data_lower_out} == cur_addr && !addr_data_oe_n))
    else $error("address not on bus");
  a_upper_en: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == EBI_ADDR) |-> (upper_byte_enable_n == !(wide && (cur_word || cur_addr[0]))))
    else $error("upper byte enable wrong");
  a_fetch_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == EBI_ADDR) |-> (fetch_indicator == cur_fetch) ##1 (fetch_indicator == cur_fetch))
    else $error("fetch indicator not steady");
  a_rom_internal: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == EBI_IDLE && req_valid && reset_seen && !program_mode && ext_latched_n
     && req_addr >= ROM_LO && req_addr <= ROM_HI) |=> (req_internal && state == EBI_IDLE))
    else $error("ROM window access went external");
  a_ea_low_ext: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == EBI_IDLE && req_valid && reset_seen && !program_mode && !ext_latched_n) |=> state == EBI_ADDR)
    else $error("access not sent off-chip");
  a_ea_stable: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(reset_seen) && reset_seen) |-> $stable(ext_latched_n))
    else $error("external access level changed after reset");
endmodule : ebi_core

// >>> test/ebi_mem_model.sv
// External memory model: address latch plus byte-wide store.
// Assumes the device changes its pins just after core_clk rises.
`timescale 1ns/10ps
module ebi_mem_model (
  input  wire logic       core_clk,
  input  wire logic       strobe_is_latch,
  input  wire logic       wide,
  input  wire logic [7:0] up_out,
  input  wire logic [7:0] lo_out,
  input  wire logic       oe_n,
  input  wire logic       strobe,
  input  wire logic       ube_n,
  output logic      [7:0] up_in,
  output logic      [7:0] lo_in
);
  logic [7:0]  mem [256];
  logic [15:0] addr;
  logic [1:0]  ph = 2'h0;
  logic        act_q = 1'b0;
  logic [7:0]  junk = 8'h5A;
  logic        act;
  assign act = strobe_is_latch ? strobe : !strobe;
  always @(posedge core_clk) begin
    act_q <= act;
    junk  <= ~junk;
    ph    <= (ph == 2'h1) ? 2'h2 : 2'h0;
    if (act && !act_q) begin
      addr <= {up_out, lo_out};
      ph   <= 2'h1;
    end else if (ph == 2'h1 && !oe_n) begin
      if (!wide || !addr[0]) mem[addr[7:0]] <= lo_out;
      if (wide && !ube_n) mem[{addr[7:1], 1'b1}] <= up_out;
    end
  end
  // Lanes not driven by us toggle so a stale value cannot pass
  always_comb begin
    up_in = junk;
    lo_in = ~junk;
    if (ph == 2'h1 && oe_n) begin
      lo_in = wide ? mem[{addr[7:1], 1'b0}] : mem[addr[7:0]];
      if (wide) up_in = mem[{addr[7:1], 1'b1}];
    end
  end
endmodule : ebi_mem_model

// >>> test/tb_top.sv
// Self-checking bench: bus interface against the memory model.
// Assumes ebi_pkg, ebi_core and ebi_mem_model are compiled first.
`timescale 1ns/10ps
module tb_top;
  import ebi_pkg::*;
  logic        core_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic        req_word = 1'b0, req_fetch = 1'b0, req_cfg_fetch = 1'b0, external_access_n = 1'b0;
  logic        dyn_width_enable = 1'b1, strobe_is_latch = 1'b1, dynamic_width_select = 1'b1;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, rd_data;
  logic [3:0]  program_mode_select = 4'h0, program_mode_latched;
  logic        req_done, req_internal, program_mode, addr_data_oe_n, addr_strobe;
  logic        upper_byte_enable_n, fetch_indicator;
  logic [7:0]  up_in, lo_in, up_out, lo_out;
  logic        model_wide;
  // Cycle width as the far side sees it; a config fetch obeys the pin even when disabled
  assign model_wide = dynamic_width_select || !(dyn_width_enable || req_cfg_fetch);
  int          failures = 0, checks_done = 0;
  always #5 core_clk = ~core_clk;
  ebi_core ebi_core_i (.core_clk, .nrst, .req_valid, .req_addr, .req_write, .req_word, .req_fetch,
    .req_cfg_fetch, .req_wdata, .dyn_width_enable, .strobe_is_latch, .req_done, .req_internal, .rd_data,
    .program_mode, .program_mode_latched, .addr_data_upper_in(up_in), .addr_data_lower_in(lo_in),
    .addr_data_upper_out(up_out), .addr_data_lower_out(lo_out), .addr_data_oe_n, .addr_strobe,
    .upper_byte_enable_n, .fetch_indicator, .dynamic_width_select, .external_access_n, .program_mode_select);
  ebi_mem_model ebi_mem_model_i (.core_clk, .strobe_is_latch, .wide(model_wide), .up_out,
    .lo_out, .oe_n(addr_data_oe_n), .strobe(addr_strobe), .ube_n(upper_byte_enable_n), .up_in, .lo_in);
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Strap pin is flipped right after it is caught to prove it is held
  task automatic restart(input logic ea_n, input logic [3:0] pm, input logic latch);
    @(negedge core_clk);
    nrst = 1'b0;
    external_access_n = ea_n;
    program_mode_select = pm;
    strobe_is_latch = latch;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    external_access_n = ~ea_n;
    @(negedge core_clk);
  endtask : restart
  // kind: 0 refused, 1 on-chip, 2 external bus cycle
  task automatic access(input logic [15:0] a, input logic wr, wd, fe, cf, input logic [15:0] wd_v,
                        input int kind);
    logic seen;
    logic done;
    int   n;
    seen = 1'b0;
    done = 1'b0;
    req_addr = a;
    req_write = wr;
    req_word = wd;
    req_fetch = fe;
    req_cfg_fetch = cf;
    req_wdata = wd_v;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    if (kind == 2) begin
      chk("address", {up_out, lo_out}, a);
      chk("fetch", fetch_indicator, fe && !cf);
      chk("upper enable", upper_byte_enable_n, !(model_wide && (wd || a[0])));
    end
    for (n = 0; n < 6 && !done; n++) begin
      if (strobe_is_latch ? addr_strobe : !addr_strobe) seen = 1'b1;
      if (kind == 2 && n == 1) chk("strobe mid", addr_strobe, 1'b0);
      if (req_done === 1'b1) begin
        done = 1'b1;
        chk("internal", req_internal, kind == 1);
        if (kind == 2) chk("strobe end", addr_strobe, !strobe_is_latch);
      end else @(negedge core_clk);
    end
    chk("done", done, kind != 0);
    chk("strobe used", seen, kind == 2);
    repeat (2) @(negedge core_clk);
  endtask : access
  initial begin
    restart(1'b0, 4'h0, 1'b1);
    access(16'h2010, 1'b1, 1'b1, 1'b0, 1'b0, 16'hBEEF, 2);
    access(16'h2010, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000, 2);
    chk("word read", rd_data, 16'hBEEF);
    access(16'h2011, 1'b1, 1'b0, 1'b0, 1'b0, 16'hA5A5, 2);
    access(16'h2010, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 2);
    chk("high byte", rd_data, 16'hA5EF);
    dynamic_width_select = 1'b0;
    access(16'h4023, 1'b1, 1'b0, 1'b0, 1'b0, 16'h3C3C, 2);
    access(16'h4023, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0000, 2);
    chk("narrow byte", rd_data, 16'h003C);
    dyn_width_enable = 1'b0;
    access(16'h4040, 1'b1, 1'b1, 1'b0, 1'b0, 16'h5AC3, 2);
    access(16'h4040, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 2);
    chk("width pin ignored", rd_data, 16'h5AC3);
    access(16'h4023, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 2);
    chk("config fetch width", rd_data, 16'h003C);
    dyn_width_enable = 1'b1;
    dynamic_width_select = 1'b1;
    restart(1'b1, 4'h0, 1'b0);
    access(16'h2000, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000, 1);
    access(16'h2FFF, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 1);
    access(16'h3000, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1234, 2);
    access(16'h3000, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 2);
    chk("window edge read", rd_data, 16'h1234);
    restart(1'b1, 4'h5, 1'b1);
    chk("program mode", program_mode, 1'b1);
    chk("mode pins", program_mode_latched, 16'h0005);
    access(16'h3000, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 0);
    finish_test();
  end
endmodule : tb_top
